/* File: rtl/rtc_log_regs.sv */
// register bank for clock readback, fault log fetch and user log control
//
// The strobed register port was left to the implementer.
`default_nettype none
module rtc_log_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    input wire rtc_log_regs_pkg::time_word_t cur_time,
    input wire rtc_log_regs_pkg::date_word_t cur_date,
    input wire logic [3:0] valid_logs,
    output rtc_log_regs_pkg::fetch_req_t fetch,
    output rtc_log_regs_pkg::user_log_t user_log
);

    typedef struct packed {
        rtc_log_regs_pkg::time_word_t time_snap;
        rtc_log_regs_pkg::date_word_t date_snap;
        logic [3:0] log_sel;
        logic [15:0] hdr_val;
        logic [15:0] rec_val;
        logic hdr_pulse;
        logic rec_pulse;
        logic run;
        logic arm;
        logic [6:0] post_share;
        logic [15:0] rdata;
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    rtc_log_regs_pkg::bus_req_t req;
    rtc_log_regs_pkg::date_word_t date_live;
    logic [3:0] count_sat;

    assign req = '{
        wr: wr,
        rd: rd,
        addr: addr,
        wdata: wdata
    };

    // saturate the count coming from the log store
    assign count_sat = (valid_logs > rtc_log_regs_pkg::VALID_COUNT_MAX)
        ? rtc_log_regs_pkg::VALID_COUNT_MAX : valid_logs;

    always_comb
    begin
        date_live = cur_date;
        date_live.unused = 1'b0;
        nxt_state = state_ff;
        nxt_state.hdr_pulse = 1'b0;
        nxt_state.rec_pulse = 1'b0;
        nxt_state.arm = 1'b0;
        // writes
        if (req.wr)
        begin
            case (req.addr)
                rtc_log_regs_pkg::REG_LOG_SELECT:
                begin
                    if (req.wdata <= {12'h000, rtc_log_regs_pkg::LOG_SELECT_MAX})
                    begin
                        nxt_state.log_sel = req.wdata[3:0];
                    end
                end
                rtc_log_regs_pkg::REG_HEADER_FETCH:
                begin
                    if (req.wdata <= rtc_log_regs_pkg::FETCH_GO)
                    begin
                        nxt_state.hdr_val = req.wdata;
                        nxt_state.hdr_pulse = (req.wdata == rtc_log_regs_pkg::FETCH_GO);
                    end
                end
                rtc_log_regs_pkg::REG_RECORD_FETCH:
                begin
                    nxt_state.rec_val = req.wdata;
                    nxt_state.rec_pulse = 1'b1;
                end
                rtc_log_regs_pkg::REG_USER_RUN:
                begin
                    if (req.wdata == rtc_log_regs_pkg::RUN_START)
                    begin
                        nxt_state.run = 1'b1;
                        nxt_state.arm = 1'b1;
                    end
                    else if (req.wdata == rtc_log_regs_pkg::RUN_STOP)
                    begin
                        nxt_state.run = 1'b0;
                    end
                end
                rtc_log_regs_pkg::REG_POST_SHARE:
                begin
                    if (req.wdata <= {9'h000, rtc_log_regs_pkg::POST_SHARE_MAX})
                    begin
                        nxt_state.post_share = req.wdata[6:0];
                    end
                end
                default:
                begin
                    nxt_state.rdata = state_ff.rdata;
                end
            endcase
        end
        // reads: data stands for the one cycle after the strobe
        nxt_state.rdata = rtc_log_regs_pkg::READ_ZERO;
        if (req.rd)
        begin
            case (req.addr)
                rtc_log_regs_pkg::REG_DATE_HI:
                begin
                    nxt_state.date_snap = date_live;
                    nxt_state.time_snap = cur_time;
                    nxt_state.time_snap.unused = 7'h00;
                    nxt_state.rdata = date_live[31:16];
                end
                rtc_log_regs_pkg::REG_DATE_LO:
                begin
                    nxt_state.rdata = state_ff.date_snap[15:0];
                end
                rtc_log_regs_pkg::REG_TIME_HI:
                begin
                    nxt_state.rdata = state_ff.time_snap[31:16];
                end
                rtc_log_regs_pkg::REG_TIME_LO:
                begin
                    nxt_state.rdata = state_ff.time_snap[15:0];
                end
                rtc_log_regs_pkg::REG_SAMPLE_PERIOD:
                begin
                    nxt_state.rdata = rtc_log_regs_pkg::SAMPLE_PERIOD_MS;
                end
                rtc_log_regs_pkg::REG_VALID_COUNT:
                begin
                    nxt_state.rdata = {12'h000, count_sat};
                end
                rtc_log_regs_pkg::REG_LOG_SELECT:
                begin
                    nxt_state.rdata = {12'h000, state_ff.log_sel};
                end
                rtc_log_regs_pkg::REG_HEADER_FETCH:
                begin
                    nxt_state.rdata = state_ff.hdr_val;
                end
                rtc_log_regs_pkg::REG_RECORD_FETCH:
                begin
                    nxt_state.rdata = state_ff.rec_val;
                end
                rtc_log_regs_pkg::REG_USER_RUN:
                begin
                    nxt_state.rdata = {15'h0000, state_ff.run};
                end
                rtc_log_regs_pkg::REG_POST_SHARE:
                begin
                    nxt_state.rdata = {9'h000, state_ff.post_share};
                end
                default:
                begin
                    nxt_state.rdata = rtc_log_regs_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_ff <= '0;
            state_ff.log_sel <= rtc_log_regs_pkg::LOG_SELECT_RST;
            state_ff.hdr_val <= rtc_log_regs_pkg::FETCH_RST;
            state_ff.rec_val <= rtc_log_regs_pkg::FETCH_RST;
            state_ff.post_share <= rtc_log_regs_pkg::POST_SHARE_RST;
            state_ff.run <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign rdata = state_ff.rdata;
    assign fetch = '{
        header: state_ff.hdr_pulse,
        record: state_ff.rec_pulse,
        log_sel: state_ff.log_sel,
        rec_num: state_ff.rec_val
    };
    assign user_log = '{
        run: state_ff.run,
        arm: state_ff.arm,
        post_share: state_ff.post_share
    };

    // checks
    sequence s_date_read;
        rd && (addr == rtc_log_regs_pkg::REG_DATE_HI);
    endsequence

    sequence s_date_lo_read;
        rd && (addr == rtc_log_regs_pkg::REG_DATE_LO);
    endsequence

    sequence s_time_hi_read;
        rd && (addr == rtc_log_regs_pkg::REG_TIME_HI);
    endsequence

    sequence s_time_lo_read;
        rd && (addr == rtc_log_regs_pkg::REG_TIME_LO);
    endsequence

    sequence s_hdr_go;
        wr && (addr == rtc_log_regs_pkg::REG_HEADER_FETCH)
            && (wdata == rtc_log_regs_pkg::FETCH_GO);
    endsequence

    chk_time_low_word: assert property (@(posedge clk) disable iff (!resetn)
        s_date_read ##1 s_time_lo_read |=> rdata == {$past(cur_time.minutes, 2),
            $past(cur_time.hours, 2)})
        else $error("time low word differs from snapshot");

    chk_time_set_flag: assert property (@(posedge clk) disable iff (!resetn)
        s_date_read ##1 s_time_hi_read |=> (rdata[15] == $past(cur_time.set, 2))
            && (rdata[14:8] == 7'h00))
        else $error("time set flag or unused bits wrong");

    chk_snapshot_hold: assert property (@(posedge clk) disable iff (!resetn)
        s_date_read ##1 (!(rd && (addr == rtc_log_regs_pkg::REG_DATE_HI))) [*2]
            |=> state_ff.time_snap.seconds
            == $past(cur_time.seconds, 3))
        else $error("time snapshot not held");

    chk_period_value: assert property (@(posedge clk) disable iff (!resetn)
        rd && (addr == rtc_log_regs_pkg::REG_SAMPLE_PERIOD)
            |=> rdata == rtc_log_regs_pkg::SAMPLE_PERIOD_MS)
        else $error("sample period not 1 ms");

    chk_count_range: assert property (@(posedge clk) disable iff (!resetn)
        rd && (addr == rtc_log_regs_pkg::REG_VALID_COUNT)
            |=> rdata <= {12'h000, rtc_log_regs_pkg::VALID_COUNT_MAX})
        else $error("valid log count above 12");

    chk_select_range: assert property (@(posedge clk) disable iff (!resetn)
        fetch.log_sel <= rtc_log_regs_pkg::LOG_SELECT_MAX)
        else $error("log select above 11");

    chk_header_pulse: assert property (@(posedge clk) disable iff (!resetn)
        s_hdr_go |=> fetch.header && (fetch.log_sel == $past(fetch.log_sel)))
        else $error("header fetch not requested");

    chk_header_zero: assert property (@(posedge clk) disable iff (!resetn)
        fetch.header |-> $past(wr) && ($past(wdata) == rtc_log_regs_pkg::FETCH_GO)
            && ($past(addr) == rtc_log_regs_pkg::REG_HEADER_FETCH))
        else $error("header fetch without a write of 1");

    chk_record_pulse: assert property (@(posedge clk) disable iff (!resetn)
        wr && (addr == rtc_log_regs_pkg::REG_RECORD_FETCH)
            |=> fetch.record && (fetch.rec_num == $past(wdata))
            ##1 (!fetch.record || $past(wr && (addr == rtc_log_regs_pkg::REG_RECORD_FETCH))))
        else $error("record fetch wrong");

    chk_run_start: assert property (@(posedge clk) disable iff (!resetn)
        wr && (addr == rtc_log_regs_pkg::REG_USER_RUN)
            && (wdata == rtc_log_regs_pkg::RUN_START)
            |=> user_log.run && user_log.arm
            ##1 (!user_log.arm || $past(wr && (addr == rtc_log_regs_pkg::REG_USER_RUN)
                && (wdata == rtc_log_regs_pkg::RUN_START))))
        else $error("logger not started and armed");

    chk_run_stop: assert property (@(posedge clk) disable iff (!resetn)
        wr && (addr == rtc_log_regs_pkg::REG_USER_RUN)
            && (wdata == rtc_log_regs_pkg::RUN_STOP) |=> !user_log.run)
        else $error("logger not stopped");

    chk_share_range: assert property (@(posedge clk) disable iff (!resetn)
        user_log.post_share <= rtc_log_regs_pkg::POST_SHARE_MAX)
        else $error("post trigger share above 100");

    chk_date_layout: assert property (@(posedge clk) disable iff (!resetn)
        s_date_read |=> (rdata == $past(cur_date[31:16]))
            && (state_ff.date_snap.set == $past(cur_date.set)))
        else $error("date readback wrong");

    chk_reject_select: assert property (@(posedge clk) disable iff (!resetn)
        wr && (addr == rtc_log_regs_pkg::REG_LOG_SELECT)
            && (wdata > {12'h000, rtc_log_regs_pkg::LOG_SELECT_MAX})
            |=> $stable(fetch.log_sel))
        else $error("out of range select stored");

    chk_select_store: assert property (@(posedge clk) disable iff (!resetn)
        wr && (addr == rtc_log_regs_pkg::REG_LOG_SELECT)
            && (wdata <= {12'h000, rtc_log_regs_pkg::LOG_SELECT_MAX})
            |=> fetch.log_sel == $past(wdata[3:0]))
        else $error("in range select not stored");

    chk_date_low_word: assert property (@(posedge clk) disable iff (!resetn)
        s_date_read ##1 s_date_lo_read |=> (rdata[15] == 1'b0)
            && (rdata[14:0] == $past(cur_date[14:0], 2)))
        else $error("date low word differs from snapshot");

    chk_header_reject: assert property (@(posedge clk) disable iff (!resetn)
        wr && (addr == rtc_log_regs_pkg::REG_HEADER_FETCH)
            && (wdata > rtc_log_regs_pkg::FETCH_GO) |=> !fetch.header)
        else $error("header fetch on a write above 1");

    chk_record_source: assert property (@(posedge clk) disable iff (!resetn)
        fetch.record |-> $past(wr) && ($past(addr) == rtc_log_regs_pkg::REG_RECORD_FETCH))
        else $error("record fetch without a write");

    chk_arm_source: assert property (@(posedge clk) disable iff (!resetn)
        user_log.arm |-> $past(wr) && ($past(addr) == rtc_log_regs_pkg::REG_USER_RUN)
            && ($past(wdata) == rtc_log_regs_pkg::RUN_START))
        else $error("trigger armed without a start");

    chk_run_reject: assert property (@(posedge clk) disable iff (!resetn)
        wr && (addr == rtc_log_regs_pkg::REG_USER_RUN)
            && (wdata > rtc_log_regs_pkg::RUN_START)
            |=> $stable(user_log.run) && !user_log.arm)
        else $error("run control took an out of range value");

    chk_share_store: assert property (@(posedge clk) disable iff (!resetn)
        wr && (addr == rtc_log_regs_pkg::REG_POST_SHARE)
            && (wdata <= {9'h000, rtc_log_regs_pkg::POST_SHARE_MAX})
            |=> user_log.post_share == $past(wdata[6:0]))
        else $error("in range share not stored");

    chk_share_reject: assert property (@(posedge clk) disable iff (!resetn)
        wr && (addr == rtc_log_regs_pkg::REG_POST_SHARE)
            && (wdata > {9'h000, rtc_log_regs_pkg::POST_SHARE_MAX})
            |=> $stable(user_log.post_share))
        else $error("out of range share stored");

    chk_count_value: assert property (@(posedge clk) disable iff (!resetn)
        rd && (addr == rtc_log_regs_pkg::REG_VALID_COUNT)
            && (valid_logs <= rtc_log_regs_pkg::VALID_COUNT_MAX)
            |=> rdata == {12'h000, $past(valid_logs)})
        else $error("valid log count not passed through");

endmodule
`default_nettype wire

/* File: rtl/rtc_log_regs_pkg.sv */
// shared constants and types for the rtc and data log register bank
`default_nettype none
package rtc_log_regs_pkg;
    // register numbers, one 16-bit word each; 32-bit values take two words, high word first
    localparam logic [15:0] REG_DATE_HI = 16'hA469;
    localparam logic [15:0] REG_DATE_LO = 16'hA46A;
    localparam logic [15:0] REG_TIME_HI = 16'hA46B;
    localparam logic [15:0] REG_TIME_LO = 16'hA46C;
    localparam logic [15:0] REG_SAMPLE_PERIOD = 16'hA46D;
    localparam logic [15:0] REG_VALID_COUNT = 16'hA46E;
    localparam logic [15:0] REG_FACTORY_CMD_A = 16'hA46F;
    localparam logic [15:0] REG_FACTORY_STATUS = 16'hA470;
    localparam logic [15:0] REG_LOG_SELECT = 16'hA471;
    localparam logic [15:0] REG_HEADER_FETCH = 16'hA472;
    localparam logic [15:0] REG_RECORD_FETCH = 16'hA473;
    localparam logic [15:0] REG_FACTORY_CMD_B = 16'hA474;
    localparam logic [15:0] REG_USER_RUN = 16'hA475;
    localparam logic [15:0] REG_POST_SHARE = 16'hA476;
    // fixed values and limits
    localparam logic [15:0] SAMPLE_PERIOD_MS = 16'h0001;
    localparam logic [3:0] VALID_COUNT_MAX = 4'hC;
    localparam logic [3:0] LOG_SELECT_MAX = 4'hB;
    localparam logic [15:0] FETCH_GO = 16'h0001;
    localparam logic [15:0] RUN_START = 16'h0001;
    localparam logic [15:0] RUN_STOP = 16'h0000;
    localparam logic [6:0] POST_SHARE_MAX = 7'h64;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    // reset values
    localparam logic [3:0] LOG_SELECT_RST = 4'h0;
    localparam logic [15:0] FETCH_RST = 16'h0000;
    localparam logic [6:0] POST_SHARE_RST = 7'h00;
    // time word: set flag, unused, seconds, minutes, hours
    typedef struct packed {
        logic set;
        logic [6:0] unused;
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
    } time_word_t;
    // date word: day, month, unused, set flag, year
    typedef struct packed {
        logic [7:0] day;
        logic [7:0] month;
        logic unused;
        logic set;
        logic [13:0] year;
    } date_word_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bus_req_t;
    typedef struct packed {
        logic header;
        logic record;
        logic [3:0] log_sel;
        logic [15:0] rec_num;
    } fetch_req_t;
    typedef struct packed {
        logic run;
        logic arm;
        logic [6:0] post_share;
    } user_log_t;
endpackage
`default_nettype wire

/* File: bench/rtc_log_regs_tb.sv */
// self-checking testbench for the rtc and data log register bank
`default_nettype none
module rtc_log_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    rtc_log_regs_pkg::time_word_t cur_time = '0;
    rtc_log_regs_pkg::date_word_t cur_date = '0;
    logic [3:0] valid_logs = 4'h0;
    rtc_log_regs_pkg::fetch_req_t fetch;
    rtc_log_regs_pkg::user_log_t user_log;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    rtc_log_regs u_dut (.clk(clk), .resetn(resetn), .wr(wr), .rd(rd), .addr(addr),
        .wdata(wdata), .rdata(rdata), .cur_time(cur_time), .cur_date(cur_date),
        .valid_logs(valid_logs), .fetch(fetch), .user_log(user_log));
    always #2 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // cycle ceiling against hangs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            $display("unexpected at %0t: timeout", $time);
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic read_check(input logic [15:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp, what);
    endtask
    task automatic next_cycle();
        @(posedge clk);
        #1;
    endtask
    task automatic test_reset();
        check(fetch, '0, "fetch after reset");
        check(user_log, '0, "user log after reset");
        read_check(rtc_log_regs_pkg::REG_LOG_SELECT, 16'h0000, "select reset");
        read_check(rtc_log_regs_pkg::REG_POST_SHARE, 16'h0000, "share reset");
        read_check(rtc_log_regs_pkg::REG_USER_RUN, 16'h0000, "run reset");
        read_check(rtc_log_regs_pkg::REG_HEADER_FETCH, 16'h0000, "header reset");
        $display("test reset done");
    endtask
    task automatic test_read_only();
        logic [3:0] lv [4] = '{4'h0, 4'h5, 4'hC, 4'hF};
        logic [15:0] ev [4] = '{16'h0000, 16'h0005, 16'h000C, 16'h000C};
        read_check(rtc_log_regs_pkg::REG_SAMPLE_PERIOD, 16'h0001, "period");
        write_reg(rtc_log_regs_pkg::REG_SAMPLE_PERIOD, 16'h0007);
        read_check(rtc_log_regs_pkg::REG_SAMPLE_PERIOD, 16'h0001, "period written");
        next_cycle();
        check(rdata, 16'h0000, "rdata after read");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            valid_logs <= lv[i];
            read_check(rtc_log_regs_pkg::REG_VALID_COUNT, ev[i], "valid count");
        end
        write_reg(rtc_log_regs_pkg::REG_VALID_COUNT, 16'h0003);
        read_check(rtc_log_regs_pkg::REG_VALID_COUNT, 16'h000C, "count written");
        read_check(rtc_log_regs_pkg::REG_FACTORY_CMD_A, 16'h0000, "factory a");
        read_check(rtc_log_regs_pkg::REG_FACTORY_STATUS, 16'h0000, "factory st");
        read_check(rtc_log_regs_pkg::REG_FACTORY_CMD_B, 16'h0000, "factory b");
        read_check(16'h1234, 16'h0000, "unmapped");
        $display("test read only done");
    endtask
    // date read first, then live values move before the remaining reads
    task automatic snap(input logic [31:0] t, input logic [31:0] d, input logic [15:0] thi,
        input logic [15:0] tlo, input logic [15:0] dhi, input logic [15:0] dlo);
        @(posedge clk);
        cur_time <= t;
        cur_date <= d;
        read_check(rtc_log_regs_pkg::REG_DATE_HI, dhi, "date hi");
        @(posedge clk);
        cur_time <= ~t;
        cur_date <= ~d;
        read_check(rtc_log_regs_pkg::REG_DATE_LO, dlo, "date lo");
        read_check(rtc_log_regs_pkg::REG_TIME_HI, thi, "time hi");
        read_check(rtc_log_regs_pkg::REG_TIME_LO, tlo, "time lo");
    endtask
    // date read and a second read back to back, no gap between strobes
    task automatic read_pair(input logic [15:0] a, input logic [15:0] dhi,
        input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= rtc_log_regs_pkg::REG_DATE_HI;
        @(posedge clk);
        addr <= a;
        #1;
        check(rdata, dhi, "pair date hi");
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp, "pair second word");
    endtask
    task automatic test_snapshot();
        read_check(rtc_log_regs_pkg::REG_TIME_HI, 16'h0000, "time before date");
        snap(32'h7F3B2A17, 32'h1503B7E1, 16'h003B, 16'h2A17, 16'h1503, 16'h37E1);
        snap(32'hFF3B2A17, 32'h1503C7E1, 16'h803B, 16'h2A17, 16'h1503, 16'h47E1);
        @(posedge clk);
        cur_time <= 32'h80112233;
        cur_date <= 32'h0C0BC123;
        read_pair(rtc_log_regs_pkg::REG_TIME_LO, 16'h0C0B, 16'h2233);
        read_pair(rtc_log_regs_pkg::REG_TIME_HI, 16'h0C0B, 16'h8011);
        read_pair(rtc_log_regs_pkg::REG_DATE_LO, 16'h0C0B, 16'h4123);
        $display("test snapshot done");
    endtask
    task automatic test_select();
        write_reg(rtc_log_regs_pkg::REG_LOG_SELECT, 16'h000B);
        check(fetch.log_sel, 4'hB, "select max");
        write_reg(rtc_log_regs_pkg::REG_LOG_SELECT, 16'h000C);
        check(fetch.log_sel, 4'hB, "select over");
        write_reg(rtc_log_regs_pkg::REG_LOG_SELECT, 16'hFFFF);
        read_check(rtc_log_regs_pkg::REG_LOG_SELECT, 16'h000B, "select kept");
        $display("test select done");
    endtask
    task automatic test_fetch();
        write_reg(rtc_log_regs_pkg::REG_LOG_SELECT, 16'h0003);
        write_reg(rtc_log_regs_pkg::REG_HEADER_FETCH, 16'h0001);
        check({fetch.header, fetch.record, fetch.log_sel}, 6'h23, "header pulse");
        next_cycle();
        check(fetch.header, 1'b0, "header end");
        write_reg(rtc_log_regs_pkg::REG_HEADER_FETCH, 16'h0000);
        check(fetch.header, 1'b0, "header zero");
        write_reg(rtc_log_regs_pkg::REG_HEADER_FETCH, 16'h0002);
        check(fetch.header, 1'b0, "header two");
        read_check(rtc_log_regs_pkg::REG_HEADER_FETCH, 16'h0000, "header kept");
        write_reg(rtc_log_regs_pkg::REG_RECORD_FETCH, 16'hFFFF);
        check({fetch.record, fetch.rec_num}, 17'h1FFFF, "record max");
        read_check(rtc_log_regs_pkg::REG_RECORD_FETCH, 16'hFFFF, "record rb");
        check(fetch.record, 1'b0, "record end");
        write_reg(rtc_log_regs_pkg::REG_RECORD_FETCH, 16'h0000);
        check({fetch.record, fetch.header, fetch.rec_num}, 18'h20000, "record zero");
        $display("test fetch done");
    endtask
    task automatic test_user_log();
        write_reg(rtc_log_regs_pkg::REG_USER_RUN, 16'h0001);
        check({user_log.run, user_log.arm}, 2'b11, "start");
        next_cycle();
        check({user_log.run, user_log.arm}, 2'b10, "arm end");
        write_reg(rtc_log_regs_pkg::REG_USER_RUN, 16'h0002);
        check({user_log.run, user_log.arm}, 2'b10, "run two");
        read_check(rtc_log_regs_pkg::REG_USER_RUN, 16'h0001, "run rb");
        write_reg(rtc_log_regs_pkg::REG_USER_RUN, 16'h0000);
        check({user_log.run, user_log.arm}, 2'b00, "stop");
        write_reg(rtc_log_regs_pkg::REG_POST_SHARE, 16'h0064);
        check(user_log.post_share, 7'h64, "share max");
        write_reg(rtc_log_regs_pkg::REG_POST_SHARE, 16'h0065);
        read_check(rtc_log_regs_pkg::REG_POST_SHARE, 16'h0064, "share over");
        write_reg(rtc_log_regs_pkg::REG_POST_SHARE, 16'h0000);
        check(user_log.post_share, 7'h00, "share zero");
        $display("test user log done");
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        next_cycle();
        test_reset();
        test_read_only();
        test_snapshot();
        test_select();
        test_fetch();
        test_user_log();
        finish_test();
    end
endmodule
`default_nettype wire
